// [bcc_bus_config.sv]
// bus controller configuration register with its decoded controls and arbiter
// assumes mode pins and the external request pin are asynchronous to clk_sys;
// rst is the power-on reset, manual_rst a warm reset from logic on clk_sys
//
// The implementer's own choices: the register offsets and strobed register access.
`default_nettype none

// Summary of operation
// - input_pullup_en is high while the input pull-up field is 0, and the field resets to 0.
// - output pull-ups apply to a pin group only while it is not driven and the field is 0.
// - area 1 runs byte control mode when its field is 1, normal mode at 0, reset 0.
// - area 4 runs byte control mode when its field is 1, normal mode at 0, reset 0.
// - an area on the multiplexed interface ignores its byte control setting.
// - in master startup external and bridge requests are accepted only with enable at 1.
// - in slave startup bridge requests are always accepted whatever the enable field.
// - the multiplex select field moves areas 1 to 6 onto the multiplexed interface.
// - with dma priority 0 the order is release, refresh, dma, cpu, highest first.
// - with dma priority 1 no release and no refresh happen during a dma burst.
// - address group floats in standby and release at 0, and drives in standby at 1.
// - strobe group floats in standby and release at 0, and drives in both at 1.
// - the area 0 burst field picks burst rom and length, ignored when area 0 multiplexes.
// - area 0 multiplexing is caught from a mode pin after power-on reset, read only.
// - master or slave startup is caught from a mode pin after power-on reset.
module bcc_bus_config #(
    parameter int ADDR_W = 8
) (
    // clock, reset, enable
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic ce,
    input wire logic manual_rst,
    // register port
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // mode pins, asynchronous
    input wire logic mode_master_pin,
    input wire logic mode_area0_sram_pin,
    // bus requests
    input wire logic ext_breq_n_pin,
    input wire logic pci_breq,
    input wire logic refresh_req,
    input wire logic dma_req,
    input wire logic dma_burst_active,
    input wire logic cpu_req,
    input wire logic standby,
    // pull-up controls
    output logic input_pullup_en,
    output logic addr_pullup_en,
    output logic strobe_pullup_en,
    // drive controls
    output logic addr_group_drive,
    output logic strobe_group_drive,
    // request acceptance and grants
    output logic ext_breq_accept,
    output logic pci_breq_accept,
    output logic grant_release,
    output logic grant_refresh,
    output logic grant_dma,
    output logic grant_cpu,
    // area configuration
    output logic [13:0] area_if,
    output logic area1_byte_mode,
    output logic area4_byte_mode,
    output logic [5:0] area0_burst_len,
    output logic master_mode,
    output logic straps_valid
);

    typedef struct packed {
        logic breq_s1;
        logic breq_s2;
        logic master_s1;
        logic master_s2;
        logic a0sram_s1;
        logic a0sram_s2;
        logic [1:0] strap_wait;
        logic straps_valid;
        logic slave_flag;
        logic area0_multiplex_flag;
        logic input_pullup_off;
        logic output_pullup_off;
        logic area1_byte_control;
        logic area4_byte_control;
        logic bus_request_accept_enable;
        logic areas_multiplex_select;
        logic dma_burst_priority;
        logic address_hiz_control;
        logic strobe_hiz_control;
        logic [2:0] area0_burst_field;
        logic [31:0] rdata;
    } bcc_state_t;

    localparam logic [31:0] RV = bcc_pkg::BCC_BUS_CONTROL_ONE_RST;
    localparam bcc_state_t RST_STATE = '{
        breq_s1: bcc_pkg::BCC_PIN_IDLE_N,
        breq_s2: bcc_pkg::BCC_PIN_IDLE_N,
        master_s1: 1'b0,
        master_s2: 1'b0,
        a0sram_s1: 1'b0,
        a0sram_s2: 1'b0,
        strap_wait: 2'h0,
        straps_valid: 1'b0,
        slave_flag: RV[bcc_pkg::BCC_SLAVE_FLAG_POS],
        area0_multiplex_flag: RV[bcc_pkg::BCC_AREA0_MPX_POS],
        input_pullup_off: RV[bcc_pkg::BCC_IN_PULLUP_POS],
        output_pullup_off: RV[bcc_pkg::BCC_OUT_PULLUP_POS],
        area1_byte_control: RV[bcc_pkg::BCC_A1_BYTE_POS],
        area4_byte_control: RV[bcc_pkg::BCC_A4_BYTE_POS],
        bus_request_accept_enable: RV[bcc_pkg::BCC_BREQ_EN_POS],
        areas_multiplex_select: RV[bcc_pkg::BCC_MPX_SEL_POS],
        dma_burst_priority: RV[bcc_pkg::BCC_DMA_PRIO_POS],
        address_hiz_control: RV[bcc_pkg::BCC_ADDR_HIZ_POS],
        strobe_hiz_control: RV[bcc_pkg::BCC_STROBE_HIZ_POS],
        area0_burst_field: RV[bcc_pkg::BCC_A0_BURST_LSB +: 3],
        rdata: 32'h0000_0000
    };

    bcc_state_t st_reg;
    bcc_state_t st_next;
    logic hit;
    logic [31:0] image;
    logic release_req;
    logic [2:0] a0_code;

    // interface seen by an area from its multiplex and burst settings
    function automatic logic [1:0] area_if_of(input logic multiplexed_address_data_interface, input logic burst);
        if (multiplexed_address_data_interface) begin
            return bcc_pkg::BCC_IF_MPX;
        end else if (burst) begin
            return bcc_pkg::BCC_IF_BURST;
        end
        return bcc_pkg::BCC_IF_SRAM;
    endfunction

    // burst length of a burst field, zero for off or reserved codes
    function automatic logic [5:0] burst_len_of(input logic [2:0] code);
        case (code)
            bcc_pkg::BCC_BURST_4: return bcc_pkg::BCC_LEN_4;
            bcc_pkg::BCC_BURST_8: return bcc_pkg::BCC_LEN_8;
            bcc_pkg::BCC_BURST_16: return bcc_pkg::BCC_LEN_16;
            bcc_pkg::BCC_BURST_32: return bcc_pkg::BCC_LEN_32;
            default: return bcc_pkg::BCC_LEN_NONE;
        endcase
    endfunction

    assign hit = (reg_addr == ADDR_W'(bcc_pkg::BCC_BUS_CONTROL_ONE_OFF));

    // read image; reserved and out-of-scope bits read as zero
    always_comb begin
        image = 32'h0000_0000;
        image[bcc_pkg::BCC_SLAVE_FLAG_POS] = st_reg.slave_flag;
        image[bcc_pkg::BCC_AREA0_MPX_POS] = st_reg.area0_multiplex_flag;
        image[bcc_pkg::BCC_IN_PULLUP_POS] = st_reg.input_pullup_off;
        image[bcc_pkg::BCC_OUT_PULLUP_POS] = st_reg.output_pullup_off;
        image[bcc_pkg::BCC_A1_BYTE_POS] = st_reg.area1_byte_control;
        image[bcc_pkg::BCC_A4_BYTE_POS] = st_reg.area4_byte_control;
        image[bcc_pkg::BCC_BREQ_EN_POS] = st_reg.bus_request_accept_enable;
        image[bcc_pkg::BCC_MPX_SEL_POS] = st_reg.areas_multiplex_select;
        image[bcc_pkg::BCC_DMA_PRIO_POS] = st_reg.dma_burst_priority;
        image[bcc_pkg::BCC_ADDR_HIZ_POS] = st_reg.address_hiz_control;
        image[bcc_pkg::BCC_STROBE_HIZ_POS] = st_reg.strobe_hiz_control;
        image[bcc_pkg::BCC_A0_BURST_LSB +: 3] = st_reg.area0_burst_field;
    end

    always_comb begin
        st_next = st_reg;
        // the first stage of each synchroniser feeds only the second
        st_next.breq_s1 = ext_breq_n_pin;
        st_next.breq_s2 = st_reg.breq_s1;
        st_next.master_s1 = mode_master_pin;
        st_next.master_s2 = st_reg.master_s1;
        st_next.a0sram_s1 = mode_area0_sram_pin;
        st_next.a0sram_s2 = st_reg.a0sram_s1;
        // straps are caught once, after the synchronisers have filled
        if (!st_reg.straps_valid) begin
            if (st_reg.strap_wait == bcc_pkg::BCC_STRAP_WAIT) begin
                st_next.straps_valid = 1'b1;
                st_next.slave_flag = ~st_reg.master_s2;
                st_next.area0_multiplex_flag = ~st_reg.a0sram_s2;
            end else begin
                st_next.strap_wait = st_reg.strap_wait + 2'h1;
            end
        end
        // manual reset is deliberately not looked at here
        if (reg_wr && hit) begin
            st_next.input_pullup_off = reg_wdata[bcc_pkg::BCC_IN_PULLUP_POS];
            st_next.output_pullup_off = reg_wdata[bcc_pkg::BCC_OUT_PULLUP_POS];
            st_next.area1_byte_control = reg_wdata[bcc_pkg::BCC_A1_BYTE_POS];
            st_next.area4_byte_control = reg_wdata[bcc_pkg::BCC_A4_BYTE_POS];
            st_next.bus_request_accept_enable = reg_wdata[bcc_pkg::BCC_BREQ_EN_POS];
            st_next.areas_multiplex_select = reg_wdata[bcc_pkg::BCC_MPX_SEL_POS];
            st_next.dma_burst_priority = reg_wdata[bcc_pkg::BCC_DMA_PRIO_POS];
            st_next.address_hiz_control = reg_wdata[bcc_pkg::BCC_ADDR_HIZ_POS];
            st_next.strobe_hiz_control = reg_wdata[bcc_pkg::BCC_STROBE_HIZ_POS];
            st_next.area0_burst_field = reg_wdata[bcc_pkg::BCC_A0_BURST_LSB +: 3];
        end
        // read data stand only in the cycle after the strobe
        st_next.rdata = (reg_rd && hit) ? image : 32'h0000_0000;
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            st_reg <= RST_STATE;
        end else if (ce) begin
            st_reg <= st_next;
        end
    end

    assign reg_rdata = st_reg.rdata;
    assign straps_valid = st_reg.straps_valid;
    assign master_mode = st_reg.straps_valid & ~st_reg.slave_flag;

    // nothing is accepted before the startup mode is known
    assign ext_breq_accept = master_mode & st_reg.bus_request_accept_enable
        & ~st_reg.breq_s2;
    assign pci_breq_accept = pci_breq & st_reg.straps_valid
        & (st_reg.slave_flag | st_reg.bus_request_accept_enable);
    assign release_req = ext_breq_accept | pci_breq_accept;

    bcc_arbiter u_arb (
        .clk_sys(clk_sys),
        .rst(rst),
        .ce(ce),
        .clear(manual_rst),
        .release_req(release_req),
        .refresh_req(refresh_req),
        .dma_req(dma_req),
        .cpu_req(cpu_req),
        .dma_burst_active(dma_burst_active),
        .dma_burst_priority(st_reg.dma_burst_priority),
        .grant_release(grant_release),
        .grant_refresh(grant_refresh),
        .grant_dma(grant_dma),
        .grant_cpu(grant_cpu)
    );

    // the address group floats on release whatever the field says
    assign addr_group_drive = ~grant_release
        & (~standby | st_reg.address_hiz_control);
    assign strobe_group_drive = st_reg.strobe_hiz_control
        | (~grant_release & ~standby);

    assign input_pullup_en = ~st_reg.input_pullup_off;
    assign addr_pullup_en = ~st_reg.output_pullup_off & ~addr_group_drive;
    assign strobe_pullup_en = ~st_reg.output_pullup_off & ~strobe_group_drive;

    // area 0: strap picks multiplexing, otherwise the burst field decides
    assign a0_code = st_reg.area0_multiplex_flag ? bcc_pkg::BCC_BURST_OFF
        : st_reg.area0_burst_field;
    assign area0_burst_len = burst_len_of(a0_code);

    always_comb begin
        area_if = 14'h0000;
        area_if[1:0] = area_if_of(st_reg.area0_multiplex_flag,
            burst_len_of(a0_code) != bcc_pkg::BCC_LEN_NONE);
        for (int i = 1; i < 7; i++) begin
            area_if[2*i +: 2] = area_if_of(st_reg.areas_multiplex_select, 1'b0);
        end
    end

    // multiplexing wins over byte control
    assign area1_byte_mode = st_reg.area1_byte_control
        & ~st_reg.areas_multiplex_select;
    assign area4_byte_mode = st_reg.area4_byte_control
        & ~st_reg.areas_multiplex_select;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    chk_in_pullup_write: assert property (
        (ce && reg_wr && hit) |=> (input_pullup_en == !$past(reg_wdata[25])))
        else $error("input pull-up does not follow the written field");

    chk_out_pullup_float: assert property (
        (standby && !image[15] && !image[24])
        |-> addr_pullup_en && (image[14] || strobe_pullup_en))
        else $error("address pull-up missing while floating");

    chk_byte_mode_mpx: assert property (
        (area_if[3:2] == bcc_pkg::BCC_IF_MPX) |-> !area1_byte_mode && !area4_byte_mode)
        else $error("byte control active on a multiplexed area");

    chk_byte_mode_set: assert property (
        (ce && reg_wr && hit && reg_wdata[21] && !reg_wdata[17]) |=> area1_byte_mode)
        else $error("area 1 byte control not taken");

    chk_req_enable_gate: assert property (
        (master_mode && !image[19]) |-> !ext_breq_accept && !pci_breq_accept)
        else $error("request accepted with enable off in master mode");

    chk_slave_pci_accept: assert property (
        (straps_valid && image[30] && pci_breq) |-> pci_breq_accept)
        else $error("bridge request refused in slave mode");

    chk_mpx_areas: assert property (
        (ce && reg_wr && hit && reg_wdata[17]) |=> (area_if[13:12] == bcc_pkg::BCC_IF_MPX))
        else $error("area 6 not multiplexed after select");

    chk_prio_release: assert property (
        (ce && !manual_rst && !image[16] && release_req) |=> grant_release)
        else $error("release not granted first");

    chk_prio_refresh: assert property (
        (ce && !manual_rst && !image[16] && !release_req && refresh_req) |=> grant_refresh)
        else $error("refresh not granted second");

    chk_dma_burst_lock: assert property (
        (ce && image[16] && dma_burst_active) |=> !grant_release && !grant_refresh)
        else $error("release or refresh during protected dma burst");

    chk_addr_hiz: assert property (
        grant_release |-> !addr_group_drive)
        else $error("address group driven on bus release");

    chk_strobe_drive: assert property (
        image[14] |-> strobe_group_drive)
        else $error("strobe group floats while forced to drive");

    chk_burst_ignored: assert property (
        image[29] |-> (area0_burst_len == bcc_pkg::BCC_LEN_NONE))
        else $error("area 0 burst length set while multiplexed");

    chk_strap_stable: assert property (
        $past(straps_valid) |-> $stable(image[30:29]))
        else $error("strap flags changed after capture");

    chk_strap_timing: assert property (
        $rose(straps_valid) |-> (master_mode == $past(st_reg.master_s2)))
        else $error("strap capture out of step");

    chk_manual_keep: assert property (
        (manual_rst && !(reg_wr && hit)) |=> $stable(image[25:11]))
        else $error("fields disturbed by manual reset");

    chk_read_pulse: assert property (
        (ce && reg_rd && hit) |=> (reg_rdata == $past(image)))
        else $error("read data wrong");

    cov_slave_pci: cover property (straps_valid && image[30] && pci_breq_accept);
    cov_dma_lock: cover property (image[16] && dma_burst_active && release_req ##1 grant_dma);
    cov_area0_burst: cover property (area0_burst_len == bcc_pkg::BCC_LEN_32);
    cov_release_float: cover property (grant_release && !addr_group_drive && strobe_group_drive);

endmodule

`default_nettype wire

// [bcc_pkg.sv]
// constants and types shared by the bus control configuration block
// assumes a single clk_sys domain and a plain register port with one-cycle strobes
`default_nettype none

package bcc_pkg;

    // register map
    localparam logic [7:0] BCC_BUS_CONTROL_ONE_OFF = 8'h00;
    localparam logic [31:0] BCC_BUS_CONTROL_ONE_RST = 32'h0000_0000;
    localparam logic [31:0] BCC_WRITE_MASK = 32'h033b_f800;

    // field positions inside bus_control_one
    localparam int BCC_SLAVE_FLAG_POS = 30;
    localparam int BCC_AREA0_MPX_POS = 29;
    localparam int BCC_IN_PULLUP_POS = 25;
    localparam int BCC_OUT_PULLUP_POS = 24;
    localparam int BCC_A1_BYTE_POS = 21;
    localparam int BCC_A4_BYTE_POS = 20;
    localparam int BCC_BREQ_EN_POS = 19;
    localparam int BCC_MPX_SEL_POS = 17;
    localparam int BCC_DMA_PRIO_POS = 16;
    localparam int BCC_ADDR_HIZ_POS = 15;
    localparam int BCC_STROBE_HIZ_POS = 14;
    localparam int BCC_A0_BURST_LSB = 11;

    // cycles after reset release before the mode pins are trusted
    localparam logic [1:0] BCC_STRAP_WAIT = 2'h2;
    // idle level of the active-low external request pin
    localparam logic BCC_PIN_IDLE_N = 1'b1;

    // interface codes reported per area
    localparam logic [1:0] BCC_IF_SRAM = 2'h0;
    localparam logic [1:0] BCC_IF_BURST = 2'h1;
    localparam logic [1:0] BCC_IF_MPX = 2'h2;

    // area 0 burst field encodings and burst lengths
    localparam logic [2:0] BCC_BURST_OFF = 3'h0;
    localparam logic [2:0] BCC_BURST_4 = 3'h1;
    localparam logic [2:0] BCC_BURST_8 = 3'h2;
    localparam logic [2:0] BCC_BURST_16 = 3'h3;
    localparam logic [2:0] BCC_BURST_32 = 3'h4;
    localparam logic [5:0] BCC_LEN_4 = 6'h04;
    localparam logic [5:0] BCC_LEN_8 = 6'h08;
    localparam logic [5:0] BCC_LEN_16 = 6'h10;
    localparam logic [5:0] BCC_LEN_32 = 6'h20;
    localparam logic [5:0] BCC_LEN_NONE = 6'h00;

    // bus ownership held by the arbiter
    typedef enum logic [2:0] {
        BCC_GNT_NONE,
        BCC_GNT_RELEASE,
        BCC_GNT_REFRESH,
        BCC_GNT_DMA,
        BCC_GNT_CPU
    } bcc_grant_t;

endpackage

`default_nettype wire

// [bcc_arbiter.sv]
// bus ownership arbiter: bus release, refresh, dma and cpu
// assumes requests come from logic on clk_sys; grant follows one cycle after request
`default_nettype none

module bcc_arbiter (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic ce,
    input wire logic clear,
    // requests
    input wire logic release_req,
    input wire logic refresh_req,
    input wire logic dma_req,
    input wire logic cpu_req,
    input wire logic dma_burst_active,
    input wire logic dma_burst_priority,
    // grants
    output logic grant_release,
    output logic grant_refresh,
    output logic grant_dma,
    output logic grant_cpu
);

    typedef struct packed {
        bcc_pkg::bcc_grant_t grant;
    } bcc_arb_state_t;

    bcc_arb_state_t arb_reg;
    bcc_arb_state_t arb_next;
    logic lock;

    always_comb begin
        arb_next = arb_reg;
        // an active dma burst under priority shuts out release and refresh
        lock = dma_burst_priority & dma_burst_active;
        if (clear) begin
            arb_next.grant = bcc_pkg::BCC_GNT_NONE;
        end else if (lock) begin
            if (dma_req) begin
                arb_next.grant = bcc_pkg::BCC_GNT_DMA;
            end else if (cpu_req) begin
                arb_next.grant = bcc_pkg::BCC_GNT_CPU;
            end else begin
                arb_next.grant = bcc_pkg::BCC_GNT_NONE;
            end
        end else if (release_req) begin
            arb_next.grant = bcc_pkg::BCC_GNT_RELEASE;
        end else if (refresh_req) begin
            arb_next.grant = bcc_pkg::BCC_GNT_REFRESH;
        end else if (dma_req) begin
            arb_next.grant = bcc_pkg::BCC_GNT_DMA;
        end else if (cpu_req) begin
            arb_next.grant = bcc_pkg::BCC_GNT_CPU;
        end else begin
            arb_next.grant = bcc_pkg::BCC_GNT_NONE;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            arb_reg.grant <= bcc_pkg::BCC_GNT_NONE;
        end else if (ce) begin
            arb_reg <= arb_next;
        end
    end

    assign grant_release = (arb_reg.grant == bcc_pkg::BCC_GNT_RELEASE);
    assign grant_refresh = (arb_reg.grant == bcc_pkg::BCC_GNT_REFRESH);
    assign grant_dma = (arb_reg.grant == bcc_pkg::BCC_GNT_DMA);
    assign grant_cpu = (arb_reg.grant == bcc_pkg::BCC_GNT_CPU);

endmodule

`default_nettype wire

// [bcc_ext_master.sv]
// far side of the bus controller: an external bus master and the bridge request
// assumes the bench commands the requests; both are held as levels
`default_nettype none
module bcc_ext_master (
    // clock
    input wire logic clk_sys,
    // commands from the bench
    input wire logic want_ext,
    input wire logic want_pci,
    // request lines
    output logic ext_breq_n_pin,
    output logic pci_breq
);
    timeunit 1ns;
    timeprecision 1ps;
    // the active-low pin idles high, as its pull-up would hold it
    initial begin
        ext_breq_n_pin = 1'b1;
        pci_breq = 1'b0;
    end
    always @(posedge clk_sys) begin
        ext_breq_n_pin <= !want_ext;
        pci_breq <= want_pci;
    end
endmodule
`default_nettype wire

// [tb.sv]
// self-checking bench for the bus control configuration register
// assumes bcc_pkg, bcc_bus_config and bcc_ext_master are compiled first; ce stays high
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys = 0, rst = 1, manual_rst = 0, reg_wr = 0, reg_rd = 0, standby = 0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0, reg_rdata, rd_val, img, seed = 32'h2;
    logic m_pin = 1, a0_pin = 1, want_ext = 0, want_pci = 0, ext_n, pci_breq;
    logic refresh_req = 0, dma_req = 0, dma_burst_active = 0, cpu_req = 0;
    logic in_pu, a_pu, s_pu, a_drv, s_drv, ext_acc, pci_acc, g_rel, g_ref, g_dma, g_cpu;
    logic a1_bm, a4_bm, mstr, s_valid;
    logic [13:0] area_if;
    logic [5:0] b_len;
    int failures = 0, n_checks = 0;
    always #4 clk_sys = ~clk_sys;
    bcc_ext_master far (.clk_sys(clk_sys), .want_ext(want_ext), .want_pci(want_pci),
        .ext_breq_n_pin(ext_n), .pci_breq(pci_breq));
    bcc_bus_config #(.ADDR_W(8)) dut (.clk_sys(clk_sys), .rst(rst), .ce(1'b1),
        .manual_rst(manual_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .mode_master_pin(m_pin),
        .mode_area0_sram_pin(a0_pin), .ext_breq_n_pin(ext_n), .pci_breq(pci_breq),
        .refresh_req(refresh_req), .dma_req(dma_req), .dma_burst_active(dma_burst_active),
        .cpu_req(cpu_req), .standby(standby), .input_pullup_en(in_pu),
        .addr_pullup_en(a_pu), .strobe_pullup_en(s_pu), .addr_group_drive(a_drv),
        .strobe_group_drive(s_drv), .ext_breq_accept(ext_acc), .pci_breq_accept(pci_acc),
        .grant_release(g_rel), .grant_refresh(g_ref), .grant_dma(g_dma), .grant_cpu(g_cpu),
        .area_if(area_if), .area1_byte_mode(a1_bm), .area4_byte_mode(a4_bm),
        .area0_burst_len(b_len), .master_mode(mstr), .straps_valid(s_valid));
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic [5:0] exp_len(logic [31:0] r);
        if (r[29]) return 6'h00;
        case (r[13:11])
            3'h1: return 6'h04;
            3'h2: return 6'h08;
            3'h3: return 6'h10;
            3'h4: return 6'h20;
            default: return 6'h00;
        endcase
    endfunction
    function automatic logic [13:0] exp_if(logic [31:0] r);
        logic [1:0] a0;
        a0 = r[29] ? 2'h2 : (exp_len(r) != 6'h00 ? 2'h1 : 2'h0);
        return {{6{r[17] ? 2'h2 : 2'h0}}, a0};
    endfunction
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic conclude();
        if (failures == 0 && n_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1;
        rd_val = reg_rdata;
    endtask
    task automatic check_cfg(input logic [31:0] r);
        chk("input pullup", in_pu, !r[25]);
        chk("addr drive", a_drv, !standby || r[15]);
        chk("strobe drive", s_drv, !standby || r[14]);
        chk("addr pullup", a_pu, !r[24] && standby && !r[15]);
        chk("strobe pullup", s_pu, !r[24] && standby && !r[14]);
        chk("area1 byte", a1_bm, r[21] && !r[17]);
        chk("area4 byte", a4_bm, r[20] && !r[17]);
        chk("area if", area_if, exp_if(r));
        chk("burst len", b_len, exp_len(r));
    endtask
    task automatic do_reset(input logic m, input logic a0);
        rst <= 1'b1;
        m_pin <= m;
        a0_pin <= a0;
        tick(12);
        rst <= 1'b0;
        tick(4);
        chk("straps valid", s_valid, 1'b1);
        chk("master", mstr, m);
        rd(8'h00);
        chk("reset image", rd_val, {1'b0, !m, !a0, 29'h0});
    endtask
    initial begin
        #500000;
        failures++;
        conclude();
    end
    initial begin
        do_reset(1'b1, 1'b1);
        rd(8'h04);
        chk("unmapped read", rd_val, 32'h0);
        for (int i = 0; i < 60; i++) begin
            img = (i == 0) ? 32'hffff_ffff : (i == 1) ? 32'h0 : xs();
            standby <= img[1];
            wr(8'h00, img);
            wr(8'h04, ~img);
            rd(8'h00);
            img = img & 32'h033b_f800;
            chk("image", rd_val, img);
            check_cfg(img);
        end
        manual_rst <= 1'b1;
        tick(1);
        manual_rst <= 1'b0;
        rd(8'h00);
        chk("after manual reset", rd_val, img);
        standby <= 1'b0;
        wr(8'h00, 32'h0000_8000);
        refresh_req <= 1'b1;
        dma_req <= 1'b1;
        cpu_req <= 1'b1;
        want_ext <= 1'b1;
        want_pci <= 1'b1;
        tick(5);
        chk("ext refused", ext_acc, 1'b0);
        chk("pci refused", pci_acc, 1'b0);
        chk("refresh first", g_ref, 1'b1);
        refresh_req <= 1'b0;
        tick(1);
        chk("dma next", g_dma, 1'b1);
        refresh_req <= 1'b1;
        dma_burst_active <= 1'b1;
        wr(8'h00, 32'h0009_8000);
        tick(4);
        chk("ext accepted", ext_acc, 1'b1);
        chk("burst holds", g_dma, 1'b1);
        dma_burst_active <= 1'b0;
        tick(1);
        chk("release", g_rel, 1'b1);
        chk("addr float", a_drv, 1'b0);
        chk("strobe float", s_drv, 1'b0);
        chk("pullup on float", a_pu, 1'b1);
        {refresh_req, dma_req, want_ext, want_pci} <= 4'h0;
        tick(5);
        chk("cpu last", g_cpu, 1'b1);
        cpu_req <= 1'b0;
        do_reset(1'b0, 1'b0);
        {want_ext, want_pci} <= 2'h3;
        wr(8'h00, 32'h0000_1800);
        tick(3);
        chk("slave pci", pci_acc, 1'b1);
        chk("slave ext", ext_acc, 1'b0);
        wr(8'h00, 32'h0008_1800);
        tick(1);
        chk("slave ext enabled", ext_acc, 1'b0);
        {want_ext, want_pci} <= 2'h0;
        tick(3);
        rd(8'h00);
        chk("read-only straps", rd_val, 32'h6008_1800);
        check_cfg(32'h6008_1800);
        conclude();
    end
endmodule
`default_nettype wire
